// [rtl/spmx_pkg.sv]
// shared constants and types for the flash self-programming access logic
package spmx_pkg;
    // pointer and data widths
    localparam int PTR_W = 16;                  // pointer_high_byte : pointer_low_byte
    localparam int WORD_W = 16;                 // data word r0
    // program_store_control_reg bit positions
    localparam int CB_SE    = 0;                // store_enable_bit
    localparam int CB_PAGE_ERASE_BIT = 1;                // page_erase_bit
    localparam int CB_PGWR  = 2;                // page_write_bit
    localparam int CB_RDSEL = 3;                // lock_fuse_read_select
    localparam int CB_RWWRE = 4;                // rww_read_reenable
    localparam int CB_RWWB  = 6;                // rww_busy_flag
    localparam logic [7:0] CTRL_RST = 8'h00;    // control register reset value
    // legal lower-five-bit command patterns
    localparam logic [4:0] CMD_BUFLD = 5'h01;   // page-buffer load
    localparam logic [4:0] CMD_ERASE = 5'h03;   // page erase
    localparam logic [4:0] CMD_WRITE = 5'h05;   // page write
    localparam logic [4:0] CMD_RDSEL = 5'h09;   // fuse / lock read or lock write
    localparam logic [4:0] CMD_RWWRE = 5'h11;   // read re-enable, clears page buffer
    // instruction windows in cpu cycles
    localparam logic [2:0] WIN_LOAD  = 3'h3;    // load after read select
    localparam logic [2:0] WIN_STORE = 3'h4;    // store after a command write
    // programming time per operation, microseconds
    localparam int OP_MIN_US = 3700;
    localparam int OP_MAX_US = 4500;
    // pointer values of the fuse and lock bytes
    localparam logic [15:0] FA_FUSE_LO  = 16'h0000;
    localparam logic [15:0] FA_LOCK     = 16'h0001;
    localparam logic [15:0] FA_FUSE_EXT = 16'h0002;
    localparam logic [15:0] FA_FUSE_HI  = 16'h0003;
    // controller registers on avalon-mm, byte addresses
    localparam int AV_AW = 5;
    localparam logic [4:0] REG_PTR    = 5'h00;  // pointer, rw
    localparam logic [4:0] REG_DATA   = 5'h04;  // store data word, rw
    localparam logic [4:0] REG_CTRL   = 5'h08;  // control value to write, rw
    localparam logic [4:0] REG_SEQ    = 5'h0c;  // sequence start, write only
    localparam logic [4:0] REG_STAT   = 5'h10;  // status, read only
    localparam logic [4:0] REG_RESULT = 5'h14;  // last load byte, read only
    localparam int SEQ_LOAD = 0;                // seq bit: load instead of store
    localparam int SEQ_WCTL = 1;                // seq bit: write control first
    // device operation state
    typedef enum logic [0:0] {
        OP_IDLE = 1'b0,
        OP_RUN  = 1'b1
    } spmx_op_e;
    // controller sequencer state
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_WSE   = 3'b001,
        H_WEE   = 3'b010,
        H_CTL   = 3'b011,
        H_ISS   = 3'b100,
        H_HOLD  = 3'b101,
        H_LOAD  = 3'b110,
        H_LWAIT = 3'b111
    } spmx_host_e;
endpackage

// [rtl/spmx_if.sv]
// cpu to self-programming logic connection
`timescale 1ns/1ps
interface spmx_if;
    logic        ctrl_wr;      // write strobe of the control register
    logic [7:0]  ctrl_wdata;   // value written
    logic [7:0]  ctrl_rdata;   // control register read back
    logic [15:0] ptr;          // pointer_high_byte : pointer_low_byte
    logic [15:0] data_word;    // r0
    logic        store_cmd;    // store instruction pulse
    logic        load_cmd;     // load instruction pulse
    logic [7:0]  load_data;    // load result
    logic        load_valid;   // load result pulse
    logic        cpu_halt;     // cpu halted during erase / write
    logic        ee_busy;      // eeprom_write_busy as seen by the cpu
    modport cpu (output ctrl_wr, ctrl_wdata, ptr, data_word, store_cmd, load_cmd,
                 input ctrl_rdata, load_data, load_valid, cpu_halt, ee_busy);
    modport dev (input ctrl_wr, ctrl_wdata, ptr, data_word, store_cmd, load_cmd,
                 output ctrl_rdata, load_data, load_valid, cpu_halt, ee_busy);
endinterface

// [rtl/spmx_countdown.sv]
// loadable down counter with expiry pulse
`timescale 1ns/1ps
module spmx_countdown
#(
    parameter int W = 4
)
(
    input  wire logic         core_clk,
    input  wire logic         clear,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         tick,
    output logic              live,
    output logic              expire
);
    logic [W-1:0] cnt_r;      // remaining ticks

    if (W < 1)
    begin : g_chk
        $error("spmx_countdown: W must be at least 1");
    end

    assign live = (cnt_r != '0);
    assign expire = tick && !load && (cnt_r == W'(1));

    // count down once per tick, stop at zero
    always_ff @(posedge core_clk)
    begin
        if (clear)
            cnt_r <= '0;
        else if (load)
            cnt_r <= load_val;
        else if (tick && live)
            cnt_r <= cnt_r - W'(1);
    end
endmodule

// [rtl/spmx_device.sv]
// flash self-programming access logic, device end
// Functional notes
// - address comes from 16-bit pointer register pair
// - word bits pick word, upper bits page
// - software repeats same page for erase, write
// - load addresses bytes, pointer bit zero selects
// - eeprom write blocks programming and fuse reads
// - software checks eeprom busy before control write
// - pointer one, armed read returns lock bits
// - read select clears after read or timeout
// - pointer zero returns low fuse byte
// - pointer three returns high fuse byte
// - pointer two returns extended fuse byte
// - programmed bits read zero, unprogrammed one
// - running write completes across a reset
// - operations timed by rc oscillator ticks
// - each operation lasts 3.7 to 4.5 ms
// - rww busy flag always reads zero
// - software waits, writes control, stores at once
// - command codes, store within four cycles, three after read select
// - store enable clears, held during operation
// - only five legal command patterns take effect
// - cpu halted during page erase and write
`timescale 1ns/1ps
module spmx_device
    import spmx_pkg::*;
#(
    parameter int IDX_W    = 5,                                   // page holds 2**IDX_W words
    parameter int RC_KHZ   = 8000,                                // rc oscillator rate
    parameter int OP_TICKS = (OP_MIN_US * RC_KHZ + 999) / 1000    // rc ticks per operation
)
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    spmx_if.dev                    bus,
    input  wire logic              eeprom_write_busy,
    input  wire logic              rc_osc_clk,
    input  wire logic [1:0]        lock_prog_strap,
    input  wire logic [7:0]        fuse_low_prog,
    input  wire logic [7:0]        fuse_high_prog,
    input  wire logic [7:0]        fuse_ext_prog,
    input  wire logic [7:0]        flash_rd_byte,
    output logic      [15:0]       flash_rd_addr,
    output logic                   flash_erase,
    output logic                   flash_write,
    output logic                   flash_prog_busy,
    output logic      [14-IDX_W:0] flash_page,
    output logic                   buf_wr,
    output logic                   buf_clear,
    output logic      [IDX_W-1:0]  buf_idx,
    output logic      [15:0]       buf_data,
    output logic      [1:0]        lock_prog
);
    localparam int OPW = $clog2(OP_TICKS + 1);   // operation counter width

    if (IDX_W < 1 || IDX_W > 14 || OP_TICKS < 1 || OP_TICKS * 1000 > OP_MAX_US * RC_KHZ)
    begin : g_chk
        $error("spmx_device: page size or operation time out of range");
    end

    // synchronisers for pins
    logic [27:0]    pin_s1_r;        // first stage, read only by second
    logic [27:0]    pin_s2_r;        // second stage
    logic           rc_s3_r;         // rc edge detect
    // control and operation state
    logic [4:0]     ctrl_r;          // low five bits of the control register
    spmx_op_e       op_st_r;         // operation state
    logic           halt_r;          // cpu halt
    logic           op_write_r;      // running operation is a page write
    // load path
    logic           ld_p1_r;         // load in flight
    logic           ld_fuse_r;       // in-flight load is a fuse / lock read
    logic           ld_hit_r;        // pointer named a fuse / lock byte
    logic [1:0]     ld_sel_r;        // which fuse / lock byte
    logic [7:0]     load_data_r;
    logic           load_valid_r;
    // flash and buffer strobes
    logic           erase_r;
    logic           write_r;
    logic           bufwr_r;
    logic           bufclr_r;
    logic [14-IDX_W:0] page_r;
    logic [IDX_W-1:0]  idx_r;
    logic [15:0]    bdata_r;
    logic [15:0]    rdaddr_r;
    logic [1:0]     lock_r;          // lock bits, 1 = programmed

    // decoded pins
    wire            ee_busy    = pin_s2_r[27];
    wire            rc_tick    = pin_s2_r[26] & ~rc_s3_r;
    wire [1:0]      lock_strap = pin_s2_r[25:24];
    wire [7:0]      fl_prog    = pin_s2_r[23:16];
    wire [7:0]      fh_prog    = pin_s2_r[15:8];
    wire [7:0]      fe_prog    = pin_s2_r[7:0];

    // command decode
    wire [4:0]      wcmd      = bus.ctrl_wdata[4:0];
    wire            cmd_legal = wcmd inside {CMD_RWWRE, CMD_RDSEL, CMD_WRITE,
                                             CMD_ERASE, CMD_BUFLD};
    wire            ctrl_take = bus.ctrl_wr && cmd_legal && !ee_busy
                                && !ctrl_r[CB_SE];
    wire            armed     = ctrl_r[CB_SE] && (op_st_r == OP_IDLE);
    wire            is_rdsel  = (ctrl_r == CMD_RDSEL);
    wire            st_go     = bus.store_cmd && armed && !is_rdsel && !ee_busy;
    wire            go_erase  = st_go && (ctrl_r == CMD_ERASE);
    wire            go_write  = st_go && (ctrl_r == CMD_WRITE);
    wire            go_bufld  = st_go && (ctrl_r == CMD_BUFLD);
    wire            go_rwwre  = st_go && (ctrl_r == CMD_RWWRE);
    wire            go_lock   = bus.store_cmd && armed && is_rdsel && !ee_busy;
    wire            ld_fuse   = bus.load_cmd && armed && is_rdsel && !ee_busy;
    wire            op_start  = go_erase || go_write || go_lock;
    wire            win_exp;         // no instruction came in the window
    wire            op_done;         // operation time elapsed
    wire [2:0]      win_len   = (wcmd == CMD_RDSEL) ? WIN_LOAD : WIN_STORE;
    wire            ctrl_clr  = go_bufld || go_rwwre || ld_fuse || (armed && win_exp);
    wire            hold_op   = (op_st_r == OP_RUN);

    // fuse and lock bytes, inverted so programmed bits read zero
    wire [7:0]      fuse_val  = (ld_sel_r == FA_FUSE_LO[1:0])  ? ~fl_prog :
                                (ld_sel_r == FA_LOCK[1:0])     ? {6'h3f, ~lock_r} :
                                (ld_sel_r == FA_FUSE_EXT[1:0]) ? ~fe_prog :
                                                                 ~fh_prog;

    // window of cpu cycles after a control write
    spmx_countdown #(.W(3)) u_win
    (
        .core_clk (core_clk),
        .clear    (reset),
        .load     (ctrl_take),
        .load_val (win_len),
        .tick     (1'b1),
        .live     (),
        .expire   (win_exp)
    );

    // operation timer on rc ticks, left running through a reset
    spmx_countdown #(.W(OPW)) u_op
    (
        .core_clk (core_clk),
        .clear    (reset && !hold_op),
        .load     (op_start),
        .load_val (OPW'(OP_TICKS)),
        .tick     (rc_tick),
        .live     (),
        .expire   (op_done)
    );

    // two-flop synchronisers for every pin input
    always_ff @(posedge core_clk)
    begin
        pin_s1_r <= {eeprom_write_busy, rc_osc_clk, lock_prog_strap,
                     fuse_low_prog, fuse_high_prog, fuse_ext_prog};
        pin_s2_r <= pin_s1_r;
        rc_s3_r  <= pin_s2_r[26];
    end

    // control bits and operation state; a running operation survives reset
    always_ff @(posedge core_clk)
    begin
        if (reset && !hold_op)
        begin
            ctrl_r     <= CTRL_RST[4:0];
            op_st_r    <= OP_IDLE;
            halt_r     <= 1'b0;
            op_write_r <= 1'b0;
        end
        else
        begin
            case (op_st_r)
                OP_IDLE:
                begin
                    if (ctrl_take)
                        ctrl_r <= wcmd;
                    else if (ctrl_clr)
                        ctrl_r <= CTRL_RST[4:0];
                    if (op_start)
                    begin
                        op_st_r    <= OP_RUN;
                        halt_r     <= go_erase || go_write;
                        op_write_r <= go_write;
                    end
                end
                OP_RUN:
                begin
                    if (op_done)
                    begin
                        ctrl_r  <= CTRL_RST[4:0];
                        op_st_r <= OP_IDLE;
                        halt_r  <= 1'b0;
                    end
                end
                default:
                begin
                    ctrl_r  <= CTRL_RST[4:0];
                    op_st_r <= OP_IDLE;
                    halt_r  <= 1'b0;
                end
            endcase
        end
    end

    // flash and page-buffer strobes; buffer wipes on reset, re-enable, write end
    always_ff @(posedge core_clk)
    begin
        erase_r  <= go_erase;
        write_r  <= go_write;
        bufwr_r  <= go_bufld && !reset;
        bufclr_r <= reset || go_rwwre || (hold_op && op_done && op_write_r);
        if (go_erase || go_write)
            page_r <= bus.ptr[15:IDX_W+1];
        if (go_bufld)
        begin
            idx_r   <= bus.ptr[IDX_W:1];
            bdata_r <= bus.data_word;
        end
    end

    // lock bits: taken from the strap at reset, programmed by a lock write
    always_ff @(posedge core_clk)
    begin
        if (reset && !hold_op)
            lock_r <= lock_strap;
        else if (go_lock)
            lock_r <= lock_r | ~bus.data_word[1:0];
    end

    // loads: byte address one cycle, data the next
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ld_p1_r      <= 1'b0;
            load_valid_r <= 1'b0;
            load_data_r  <= 8'h00;
            ld_fuse_r    <= 1'b0;
            ld_hit_r     <= 1'b0;
            ld_sel_r     <= 2'h0;
            rdaddr_r     <= 16'h0000;
        end
        else
        begin
            ld_p1_r      <= bus.load_cmd;
            ld_fuse_r    <= ld_fuse;
            ld_hit_r     <= (bus.ptr[15:2] == 14'h0000);
            ld_sel_r     <= bus.ptr[1:0];
            if (bus.load_cmd)
                rdaddr_r <= bus.ptr;
            load_valid_r <= ld_p1_r;
            if (ld_p1_r)
                load_data_r <= !ld_fuse_r ? flash_rd_byte :
                               ld_hit_r   ? fuse_val : 8'hff;
        end
    end

    // read back: rww_busy_flag and the upper bits are always zero
    assign bus.ctrl_rdata = {1'b0, 1'b0, 1'b0, ctrl_r};
    assign bus.load_data  = load_data_r;
    assign bus.load_valid = load_valid_r;
    assign bus.cpu_halt   = halt_r;
    assign bus.ee_busy    = ee_busy;
    assign flash_rd_addr   = rdaddr_r;
    assign flash_erase     = erase_r;
    assign flash_write     = write_r;
    assign flash_prog_busy = hold_op;
    assign flash_page      = page_r;
    assign buf_wr          = bufwr_r;
    assign buf_clear       = bufclr_r;
    assign buf_idx         = idx_r;
    assign buf_data        = bdata_r;
    assign lock_prog       = lock_r;
endmodule

// [rtl/spmx_host.sv]
// cpu-side sequencer, driven by software over avalon-mm
`timescale 1ns/1ps
module spmx_host
    import spmx_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [AV_AW-1:0] avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    spmx_if.cpu                   bus
);
    spmx_host_e   st_r;          // sequencer state
    spmx_host_e   st_nxt;
    logic [15:0]  ptr_r;         // pointer value
    logic [15:0]  data_r;        // store data word
    logic [7:0]   ctl_r;         // control value to write
    logic [1:0]   seq_r;         // latched sequence kind
    logic [7:0]   result_r;      // last load byte
    logic [31:0]  rdata_r;
    logic         wait_r;        // waitrequest
    logic         cwr_r;
    logic         stcmd_r;       // store instruction pulse
    logic         ldcmd_r;       // load instruction pulse

    // bus decode: an access completes on the second cycle
    wire          acc     = (avs_read || avs_write) && !wait_r;
    wire          wr_now  = avs_write && !wait_r;
    wire          idle    = (st_r == H_IDLE);
    wire          w_ptr   = wr_now && (avs_address == REG_PTR) && idle;
    wire          w_data  = wr_now && (avs_address == REG_DATA) && idle;
    wire          w_ctl   = wr_now && (avs_address == REG_CTRL) && idle;
    wire          start   = wr_now && (avs_address == REG_SEQ) && idle;
    wire          se_busy = bus.ctrl_rdata[CB_SE] || bus.cpu_halt;
    wire [31:0]   stat    = {16'h0000, bus.ctrl_rdata, 4'h0, bus.cpu_halt,
                             bus.ee_busy, 1'b0, !idle};
    wire [31:0]   rmux    = (avs_address == REG_PTR)    ? {16'h0000, ptr_r} :
                            (avs_address == REG_DATA)   ? {16'h0000, data_r} :
                            (avs_address == REG_CTRL)   ? {24'h000000, ctl_r} :
                            (avs_address == REG_STAT)   ? stat :
                            (avs_address == REG_RESULT) ? {24'h000000, result_r} :
                                                          32'h00000000;

    // next state of the store / load sequence
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            H_IDLE:
                if (start)
                    st_nxt = (avs_writedata[SEQ_LOAD] && !avs_writedata[SEQ_WCTL])
                             ? H_LOAD : H_WSE;
            H_WSE:
                if (!se_busy)
                    st_nxt = H_WEE;
            H_WEE:
                if (!bus.ee_busy)
                    st_nxt = H_CTL;
            H_CTL:
                st_nxt = seq_r[SEQ_LOAD] ? H_LOAD : H_ISS;
            H_ISS:
                st_nxt = H_HOLD;
            H_HOLD:
                if (!se_busy)
                    st_nxt = H_IDLE;
            H_LOAD:
                st_nxt = H_LWAIT;
            H_LWAIT:
                if (bus.load_valid)
                    st_nxt = H_IDLE;
            default:
                st_nxt = H_IDLE;
        endcase
    end

    // sequencer and strobes to the device
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_r     <= H_IDLE;
            cwr_r    <= 1'b0;
            stcmd_r  <= 1'b0;
            ldcmd_r  <= 1'b0;
        end
        else
        begin
            st_r     <= st_nxt;
            cwr_r    <= (st_nxt == H_CTL);
            stcmd_r  <= (st_nxt == H_ISS);
            ldcmd_r  <= (st_nxt == H_LOAD);
        end
    end

    // software registers; the same page is software's job for erase and write
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ptr_r    <= 16'h0000;
            data_r   <= 16'h0000;
            ctl_r    <= CTRL_RST;
            seq_r    <= 2'h0;
            result_r <= 8'h00;
        end
        else
        begin
            if (w_ptr)
                ptr_r <= avs_writedata[15:0];
            if (w_data)
                data_r <= avs_writedata[15:0];
            if (w_ctl)
                ctl_r <= avs_writedata[7:0];
            if (start)
                seq_r <= avs_writedata[1:0];
            if (st_r == H_LWAIT && bus.load_valid)
                result_r <= bus.load_data;
        end
    end

    // avalon slave: waitrequest low for one cycle per access
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            wait_r  <= !((avs_read || avs_write) && wait_r) || acc;
            if (avs_read && wait_r)
                rdata_r <= rmux;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign bus.ctrl_wr     = cwr_r;
    assign bus.ctrl_wdata  = ctl_r;
    assign bus.ptr         = ptr_r;
    assign bus.data_word   = data_r;
    assign bus.store_cmd   = stcmd_r;
    assign bus.load_cmd    = ldcmd_r;
endmodule

// [test/spmx_checker_sva.sv]
// link checker for the cpu to self-programming connection
`timescale 1ns/1ps
module spmx_checker
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        ctrl_wr,
    input wire logic [7:0]  ctrl_wdata,
    input wire logic [7:0]  ctrl_rdata,
    input wire logic [15:0] ptr,
    input wire logic        store_cmd,
    input wire logic        load_cmd,
    input wire logic [7:0]  load_data,
    input wire logic        load_valid,
    input wire logic        cpu_halt,
    input wire logic        ee_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // the five accepted command patterns
    wire legal_cmd = ctrl_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11};
    AST_RWWB: assert property (ctrl_rdata[6] == 1'b0) else $error("rww busy set");
    AST_LDV: assert property (load_cmd |-> ##2 load_valid) else $error("no load result");
    AST_LOCK: assert property (load_cmd && ctrl_rdata == 8'h09 && ptr == 16'h0001 && !ee_busy
        |-> ##2 load_data[7:2] == 6'h3f) else $error("lock byte upper bits");
    AST_RDCLR: assert property (load_cmd && ctrl_rdata[3] |=> ctrl_rdata[3:0] == 4'h0)
        else $error("read select kept");
    AST_SETO: assert property ($rose(ctrl_rdata[0]) && ctrl_rdata[3:1] == 3'h0
        |-> ##[1:5] !ctrl_rdata[0]) else $error("store enable kept");
    AST_HALT: assert property (store_cmd && !ee_busy
        && (ctrl_rdata[4:0] == 5'h03 || ctrl_rdata[4:0] == 5'h05) |=> cpu_halt)
        else $error("cpu not halted");
    AST_HOLD: assert property (cpu_halt |-> ctrl_rdata[0]) else $error("enable dropped");
    AST_EEBLK: assert property (ctrl_wr && ee_busy && !ctrl_rdata[0] |=> !ctrl_rdata[0])
        else $error("armed during eeprom write");
    AST_ILLEG: assert property (ctrl_wr && !legal_cmd && !ctrl_rdata[0] |=> !ctrl_rdata[0])
        else $error("illegal pattern armed");
    AST_ARM: assert property (ctrl_wr && legal_cmd && !ee_busy && !ctrl_rdata[0]
        |=> ctrl_rdata[4:0] == $past(ctrl_wdata[4:0])) else $error("command not armed");
endmodule

// [test/flash_self_program_access_tb_top.sv]
// testbench joining controller and flash end
`timescale 1ns/1ps
module flash_self_program_access_tb_top;
    import spmx_pkg::*;
    logic core_clk, reset, rd, wr, ee, rc;
    logic [4:0]  adr;
    logic [31:0] wd, rv;
    wire  [31:0] rdata;
    wire         wreq, fe, fw, fpb, bw, bc;
    wire  [15:0] fra, bd;
    wire  [9:0]  pg;
    wire  [4:0]  bi;
    wire  [1:0]  lp;
    logic [15:0] cd;
    logic [9:0]  cp, cw;
    logic [4:0]  ci;
    int n_mismatch, samples_checked, tick, nb, nc;
    // expected fuse bytes for pointer 0..3, programmed bits read zero
    logic [7:0] fz[4] = '{~8'h62, 8'hfe, ~8'h07, ~8'h19};
    initial begin core_clk = 0; forever #2.5 core_clk = ~core_clk; end
    spmx_if u_spmx_if();
    spmx_host u_spmx_host(.core_clk(core_clk), .reset(reset), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .bus(u_spmx_if));
    spmx_device #(.OP_TICKS(8)) u_spmx_device(.core_clk(core_clk), .reset(reset),
        .bus(u_spmx_if), .eeprom_write_busy(ee), .rc_osc_clk(rc), .lock_prog_strap(2'b01),
        .fuse_low_prog(8'h62), .fuse_high_prog(8'h19), .fuse_ext_prog(8'h07),
        .flash_rd_byte(fra[7:0] ^ 8'h5a), .flash_rd_addr(fra), .flash_erase(fe),
        .flash_write(fw), .flash_prog_busy(fpb), .flash_page(pg), .buf_wr(bw),
        .buf_clear(bc), .buf_idx(bi), .buf_data(bd), .lock_prog(lp));
    spmx_checker u_spmx_checker(.core_clk(core_clk), .reset(reset),
        .ctrl_wr(u_spmx_if.ctrl_wr), .ctrl_wdata(u_spmx_if.ctrl_wdata),
        .ctrl_rdata(u_spmx_if.ctrl_rdata), .ptr(u_spmx_if.ptr),
        .store_cmd(u_spmx_if.store_cmd), .load_cmd(u_spmx_if.load_cmd),
        .load_data(u_spmx_if.load_data), .load_valid(u_spmx_if.load_valid),
        .cpu_halt(u_spmx_if.cpu_halt), .ee_busy(u_spmx_if.ee_busy));
    // capture buffer and page strobes, and cut a hang short
    always @(posedge core_clk)
    begin
        if (bw) begin ci <= bi; cd <= bd; end
        if (fe) cp <= pg;
        if (fw) cw <= pg;
        if (fpb) nb++;
        if (bc) nc++;
        if (tick % 5 == 0) rc <= ~rc;   // rc oscillator pin, one rise per 10 cycles
        tick++;
        if (tick > 20000) begin n_mismatch++; print_verdict(); end
    end
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do @(posedge core_clk); while (wreq !== 1'b0);
        rv = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    // pointer, control, sequence start, wait idle, fetch result
    // e raises eeprom busy as the sequence starts: it lands after the host's
    // busy check and before its control write
    task automatic run(input logic [15:0] p, input logic [7:0] c, input logic [1:0] s,
                       input logic e);
        bus(1, REG_PTR, p); bus(1, REG_CTRL, c); bus(1, REG_SEQ, s);
        ee <= e;
        do bus(0, REG_STAT, 0); while (rv[0] !== 1'b0);
        bus(0, REG_RESULT, 0);
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", s, e, g); end
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        reset = 1; rd = 0; wr = 0; adr = 0; wd = 0; ee = 0; rc = 0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        bus(0, REG_STAT, 0);
        chk("rww", 16'h0, {15'h0, rv[14]});
        for (int i = 0; i < 4; i++) begin run(i, 8'h09, 2'h3, 0); chk("fuse", fz[i], rv[7:0]); end
        run(16'h0005, 8'h00, 2'h1, 0); chk("byte", 16'h5f, rv[7:0]);
        $display("test read done");
        bus(1, REG_DATA, 16'hbeef); run(16'h0046, 8'h01, 2'h0, 0);
        chk("idx", 16'h3, ci);
        chk("data", 16'hbeef, cd);
        run(16'h0440, 8'h03, 2'h0, 0); chk("page", 16'h11, cp);
        nb = 0; nc = 0; run(16'h0440, 8'h05, 2'h0, 0); chk("wpage", 16'h11, cw);
        chk("busy", 16'h1, {15'h0, nb >= 71 && nb <= 80});
        chk("bufclr", 16'h1, nc);
        bus(1, REG_DATA, 16'hfffd); run(16'h0001, 8'h09, 2'h0, 0); chk("lock", 16'h3, lp);
        run(16'h0001, 8'h09, 2'h3, 0); chk("lockrd", 16'hfc, rv[7:0]);
        $display("test store done");
        run(16'h0000, 8'h09, 2'h3, 1); chk("eeblk", 16'h5a, rv[7:0]);
        ee <= 1'b0; run(16'h0003, 8'h07, 2'h3, 0); chk("illeg", 16'h59, rv[7:0]);
        $display("test refuse done");
        print_verdict();
    end
endmodule
